/* logic/vws_regs.svh */
// What this block does
// (RL1) Serial output sends word bit zero first and bit fifteen last.
// (RL2) Latch mode select high bypasses the FIFO; inputs act as transparent latches.
// (RL3) Both selects low bypass the FIFO; inputs act as one-word flip-flops.
// (RL4) Latch select low, depth select high inserts the four-word FIFO.
// (RL5) FIFO pointers clear at reset and on a depth-select low pulse, load held high.
// (RL6) Flip-flop mode captures the data inputs on the write strobe rising edge.
// (RL7) Latch mode passes the data inputs through while the write strobe is low.
// (RL8) FIFO mode stores each write-strobe rising edge into the next word.
// (RL9) First shift-clock edge after a load-strobe rise loads the word.
// (RL10) Later shift-clock edges advance the register one place each.
// (RL11) Each shifting edge takes the cascade serial input into the top bit.
// (RL12) The mid-register tap shows bit eight.
// (RL13) Shift freeze high stops shifting on shift-clock edges.
// (RL14) After freeze release the output keeps its value until the next shift edge.
// (RL15) Output override forces both taps while the internal bits keep shifting.
// (RL16) Forced value follows the override level input.
// (RL17) Load block high ignores all load-strobe edges.
// (RL18) After load block falls, the next load-strobe and shift edge pair loads again.
// (RL19) A fifth write without a load overwrites the oldest word.
// (RL20) The FIFO delivers words oldest first.
// (RL21) A load too soon after a write into an empty FIFO takes the old word.
// (RL22) Host must load after every write in flip-flop mode.
// (RL23) Strobes and shift clock are synchronised; pairs are single signals.
`ifndef VWS_REGS_SVH
`define VWS_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define VWS_CTRL_OFS        12'h000
`define VWS_STATUS_OFS      12'h004
`define VWS_SHIFT_OFS       12'h008

// ****************************************
// Control fields
// ****************************************
`define VWS_CTRL_LATCH_BIT  0
`define VWS_CTRL_DEPTH_BIT  1
`define VWS_CTRL_FREEZE_BIT 2
`define VWS_CTRL_OVR_BIT    3
`define VWS_CTRL_LEVEL_BIT  4
`define VWS_CTRL_BLOCK_BIT  5
`define VWS_CTRL_W          6
`define VWS_CTRL_RST        6'h00

// ****************************************
// Timing
// ****************************************
`define VWS_CLK_MHZ         250
`define VWS_WR_LOAD_SETUP_NS 25

`endif

/* logic/vws_pkg.sv */
package vws_pkg;

    typedef enum logic [1:0] {
        VWS_MODE_LATCH,
        VWS_MODE_FLOP,
        VWS_MODE_FIFO
    } vws_mode_t;

endpackage : vws_pkg

/* logic/vws_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module vws_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } vws_sync_t;

    vws_sync_t st_q;
    vws_sync_t st_d;

    always_comb begin
        st_d     = st_q;
        st_d.s1  = async_in;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        // A bit changes only once stages two and three agree
        st_d.lvl = (st_q.s3 & ~(st_q.s2 ^ st_q.s3)) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;

endmodule : vws_sync

`default_nettype wire

/* logic/vws_fifo_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module vws_fifo_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd;
    } vws_mem_t;

    vws_mem_t st_q;
    vws_mem_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.rd = st_q.mem[raddr];
        if (we) begin
            st_d.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rd;

endmodule : vws_fifo_mem

`default_nettype wire

/* logic/vws_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vws_regs.svh"

module vws_serializer #(
    parameter int DATA_W = 16,
    parameter int DEPTH  = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [DATA_W-1:0] pixel_data,
    input  wire logic              write_strobe,
    input  wire logic              word_load_strobe,
    input  wire logic              shift_clock,
    input  wire logic              cascade_serial_in,
    output logic                   first_bit_tap,
    output logic                   mid_register_tap
);

    // ****************************************
    // Derived constants and checks
    // ****************************************
    localparam int AW        = $clog2(DEPTH);
    localparam int CW        = AW + 1;
    localparam int SETUP_CYC = (`VWS_WR_LOAD_SETUP_NS * `VWS_CLK_MHZ + 999) / 1000;
    localparam int AGE_W     = 4;
    localparam int MID       = DATA_W / 2;

    generate
        if (DATA_W != 16) begin : g_bad_width
            $error("vws_serializer: only a sixteen-bit word is supported");
        end
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("vws_serializer: DEPTH must be a power of two, two or more");
        end
        if (SETUP_CYC >= (1 << AGE_W)) begin : g_bad_setup
            $error("vws_serializer: write-to-load setup does not fit the age counter");
        end
    endgenerate

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic              wr_lvl;
    logic              ld_lvl;
    logic              ck_lvl;
    logic              ser_lvl;
    logic [DATA_W-1:0] data_lvl;
    logic [DATA_W-1:0] fifo_rdata;

    // One synchroniser per pin, so each strobe edge is judged on its own
    vws_sync #(.W(1)) u_sync_wr (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  (write_strobe),
        .level_out (wr_lvl)
    ); // RL23

    vws_sync #(.W(1)) u_sync_ld (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  (word_load_strobe),
        .level_out (ld_lvl)
    ); // RL23

    vws_sync #(.W(1)) u_sync_ck (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  (shift_clock),
        .level_out (ck_lvl)
    ); // RL23

    vws_sync #(.W(1)) u_sync_ser (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  (cascade_serial_in),
        .level_out (ser_lvl)
    );

    vws_sync #(.W(DATA_W)) u_sync_data (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  (pixel_data),
        .level_out (data_lvl)
    );

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [`VWS_CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0]      in_word;
        logic [DATA_W-1:0]      in_old;
        logic [DATA_W-1:0]      last_word;
        logic [DATA_W-1:0]      sreg;
        logic [AW-1:0]          wr_ptr;
        logic [AW-1:0]          rd_ptr;
        logic [CW-1:0]          count;
        logic [AGE_W-1:0]       age;
        logic                   pending;
        logic                   wr_prev;
        logic                   ld_prev;
        logic                   ck_prev;
        logic                   so;
        logic                   mid;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } vws_state_t;

    vws_state_t st_q;
    vws_state_t st_d;

    vws_pkg::vws_mode_t mode;
    logic               wr_rise;
    logic               ld_rise;
    logic               ck_rise;
    logic               fresh;
    logic               push;
    logic               pop;
    logic [DATA_W-1:0]  load_word;
    logic               apb_setup;
    logic               apb_write;
    logic [31:0]        rd_val;
    logic               addr_ok;

    always_comb begin
        // Latch select takes precedence over depth select
        if (st_q.ctrl[`VWS_CTRL_LATCH_BIT]) begin
            mode = vws_pkg::VWS_MODE_LATCH; // RL2
        end else if (st_q.ctrl[`VWS_CTRL_DEPTH_BIT]) begin
            mode = vws_pkg::VWS_MODE_FIFO; // RL4
        end else begin
            mode = vws_pkg::VWS_MODE_FLOP; // RL3
        end
    end

    assign wr_rise = wr_lvl & ~st_q.wr_prev;
    assign ld_rise = ld_lvl & ~st_q.ld_prev;
    assign ck_rise = ck_lvl & ~st_q.ck_prev;
    // A write younger than the write-to-load setup is not yet visible to a load
    assign fresh   = (st_q.age != '0);
    assign push    = wr_rise && (mode == vws_pkg::VWS_MODE_FIFO);

    // ****************************************
    // Word selected for a load
    // ****************************************
    always_comb begin
        load_word = st_q.in_word;
        pop       = 1'b0;
        case (mode)
            vws_pkg::VWS_MODE_LATCH: begin
                load_word = st_q.in_word;
            end
            vws_pkg::VWS_MODE_FLOP: begin
                load_word = fresh ? st_q.in_old : st_q.in_word; // RL21
            end
            vws_pkg::VWS_MODE_FIFO: begin
                // Empty, or only a word too young to read: repeat the old word
                if (st_q.count == '0 || (st_q.count == CW'(1) && fresh)) begin
                    load_word = st_q.last_word; // RL21
                end else begin
                    load_word = fifo_rdata; // RL20
                    pop       = st_q.pending && ck_rise;
                end
            end
            default: begin
                load_word = st_q.in_word;
            end
        endcase
    end

    // ****************************************
    // APB decode
    // ****************************************
    assign apb_setup = psel & ~penable;
    // Write data lands only at the access edge, while pready is already high
    assign apb_write = psel & penable & st_q.pready & pwrite;

    always_comb begin
        addr_ok = 1'b1;
        rd_val  = '0;
        case (paddr)
            `VWS_CTRL_OFS: begin
                rd_val[`VWS_CTRL_W-1:0] = st_q.ctrl;
            end
            `VWS_STATUS_OFS: begin
                rd_val[1:0]                 = mode;
                rd_val[2]                   = st_q.pending;
                rd_val[3]                   = fresh;
                rd_val[8 +: CW]             = st_q.count;
                rd_val[12 +: AW]            = st_q.wr_ptr;
                rd_val[16 +: AW]            = st_q.rd_ptr;
            end
            `VWS_SHIFT_OFS: begin
                rd_val[DATA_W-1:0] = st_q.sreg;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d         = st_q;
        st_d.wr_prev = wr_lvl;
        st_d.ld_prev = ld_lvl;
        st_d.ck_prev = ck_lvl;

        // Register bus: answer in the access cycle right after setup
        st_d.pready  = apb_setup;
        st_d.pslverr = apb_setup & ~addr_ok;
        if (apb_setup) begin
            st_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
        end
        if (apb_write && paddr == `VWS_CTRL_OFS) begin
            st_d.ctrl = pwdata[`VWS_CTRL_W-1:0];
        end

        if (fresh) begin
            st_d.age = st_q.age - AGE_W'(1);
        end

        // Input stage
        case (mode)
            vws_pkg::VWS_MODE_LATCH: begin
                if (!wr_lvl) begin
                    st_d.in_word = data_lvl; // RL7
                end
            end
            vws_pkg::VWS_MODE_FLOP: begin
                if (wr_rise) begin
                    // Keep the word before it for a load that comes too soon
                    st_d.in_old  = st_q.in_word;
                    st_d.in_word = data_lvl; // RL6
                    st_d.age     = AGE_W'(SETUP_CYC);
                end
            end
            vws_pkg::VWS_MODE_FIFO: begin
                if (push) begin
                    st_d.wr_ptr = st_q.wr_ptr + AW'(1); // RL8
                    st_d.age    = AGE_W'(SETUP_CYC);
                end
            end
            default: begin
                st_d.in_word = st_q.in_word;
            end
        endcase

        // Occupancy; a write into a full FIFO drops the oldest word
        if (push && !pop && st_q.count == CW'(DEPTH)) begin
            st_d.rd_ptr = st_q.rd_ptr + AW'(1); // RL19
        end else if (push && !pop) begin
            st_d.count = st_q.count + CW'(1);
        end else if (pop && !push) begin
            st_d.count = st_q.count - CW'(1);
        end
        if (pop) begin
            st_d.rd_ptr = st_q.rd_ptr + AW'(1); // RL20
        end

        // Depth select low with load strobe high restarts at word zero
        if (!st_q.ctrl[`VWS_CTRL_DEPTH_BIT] && ld_lvl) begin
            st_d.wr_ptr = '0; // RL5
            st_d.rd_ptr = '0;
            st_d.count  = '0;
        end

        // Shift register on the shift clock
        // A load is taken even while frozen
        if (ck_rise) begin
            if (st_q.pending) begin
                st_d.sreg      = load_word; // RL9
                st_d.last_word = load_word;
                st_d.pending   = 1'b0;
            end else if (!st_q.ctrl[`VWS_CTRL_FREEZE_BIT]) begin
                st_d.sreg = {ser_lvl, st_q.sreg[DATA_W-1:1]}; // RL1 RL10 RL11 RL13
            end
        end

        // Load request, ignored while blocked; set after the load above so that
        // a strobe meeting the loading shift edge is kept, not cleared
        if (ld_rise && !st_q.ctrl[`VWS_CTRL_BLOCK_BIT]) begin
            st_d.pending = 1'b1; // RL17 RL18
        end

        // Taps change only when the register does, or under override
        if (st_q.ctrl[`VWS_CTRL_OVR_BIT]) begin
            st_d.so  = st_q.ctrl[`VWS_CTRL_LEVEL_BIT]; // RL15 RL16
            st_d.mid = st_q.ctrl[`VWS_CTRL_LEVEL_BIT];
        end else begin
            st_d.so  = st_q.sreg[0]; // RL1 RL14
            st_d.mid = st_q.sreg[MID]; // RL12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= '0;
            st_q.ctrl <= `VWS_CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // FIFO storage
    // ****************************************
    // Read address is the next pointer, so rdata already shows the oldest word
    vws_fifo_mem #(
        .W     (DATA_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (push),
        .waddr   (st_q.wr_ptr),
        .wdata   (data_lvl),
        .raddr   (st_d.rd_ptr),
        .rdata   (fifo_rdata)
    );

    assign prdata           = st_q.prdata;
    assign pready           = st_q.pready;
    assign pslverr          = st_q.pslverr;
    assign first_bit_tap    = st_q.so;
    assign mid_register_tap = st_q.mid;

endmodule : vws_serializer

`default_nettype wire

/* test/vws_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****
// Pixel word writer
// ****
module vws_host_model (
    input  wire logic        pclk,
    input  wire logic        req,
    input  wire logic [15:0] word,
    output logic      [15:0] pixel_data,
    output logic             write_strobe,
    output logic             done
);
    initial begin
        pixel_data = 16'h0000;
        write_strobe = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge pclk);
            if (req) begin
                pixel_data <= word;
                repeat (5) @(posedge pclk);
                write_strobe <= 1'b1;
                repeat (5) @(posedge pclk);
                write_strobe <= 1'b0;
                repeat (5) @(posedge pclk);
                // Released bus shows the inverse, never the old word
                pixel_data <= ~word;
                done <= 1'b1;
                @(posedge pclk);
                done <= 1'b0;
            end
        end
    end
endmodule : vws_host_model

`default_nettype wire

/* test/vws_serializer_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ****
// Port checker
// ****
module vws_serializer_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        shift_clock,
    input wire logic        first_bit_tap,
    input wire logic        mid_register_tap
);
    logic [5:0] ctrl_q;
    logic [3:0] quiet_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Control copy and count of cycles with no shift pin or bus activity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 6'h00;
            quiet_q <= 4'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h000) begin
                ctrl_q <= pwdata[5:0];
            end
            if (shift_clock || psel) begin
                quiet_q <= 4'h0;
            end else if (quiet_q != 4'hf) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_answer;
        pready ##1 !pready;
    endsequence

    setup_ready_a: assert property (apb_setup |=> apb_answer) else $error("no single ready after setup");
    ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_err_a: assert property (pready && !(paddr inside {12'h000, 12'h004, 12'h008})
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr inside {12'h000, 12'h004, 12'h008} |-> !pslverr)
        else $error("mapped access refused");
    ctrl_readback_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata == {26'h0, ctrl_q})
        else $error("control readback wrong");
    taps_hold_a: assert property (quiet_q >= 4'h6 |-> $stable(first_bit_tap) && $stable(mid_register_tap))
        else $error("taps moved without shift");
    override_force_a: assert property (ctrl_q[3] && $stable(ctrl_q) |-> first_bit_tap == ctrl_q[4]
        && mid_register_tap == ctrl_q[4]) else $error("override level not shown");
endmodule : vws_serializer_properties

bind vws_serializer vws_serializer_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .shift_clock, .first_bit_tap, .mid_register_tap);

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ****
// Bench
// ****
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic        write_strobe, word_load_strobe, shift_clock, cascade_serial_in;
    logic        first_bit_tap, mid_register_tap, req, done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, seed;
    logic [15:0] pixel_data, word;
    logic [15:0] q [5];
    int          err_count, checks_done;

    vws_serializer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pixel_data, .write_strobe, .word_load_strobe, .shift_clock, .cascade_serial_in,
        .first_bit_tap, .mid_register_tap);
    vws_host_model i_host (.pclk, .req, .word, .pixel_data, .write_strobe, .done);

    always #2 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Word bits first, then the cascade bits shifted in behind them
    function automatic logic exp_bit(input logic [15:0] w, input logic [31:0] c, input int k);
        return (k < 16) ? w[k] : c[k - 15];
    endfunction : exp_bit

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (t >= 50) err_count++;
    endtask : apb

    task automatic wr_word(input logic [15:0] w);
        int t;
        t = 0;
        word <= w;
        req <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (done !== 1'b1 && t < 100);
        req <= 1'b0;
        @(posedge pclk);
        if (t >= 100) err_count++;
    endtask : wr_word

    task automatic load_pulse();
        word_load_strobe <= 1'b1;
        wait_n(5);
        word_load_strobe <= 1'b0;
        wait_n(5);
    endtask : load_pulse

    task automatic shift_one(input logic cin);
        cascade_serial_in <= cin;
        wait_n(2);
        shift_clock <= 1'b1;
        wait_n(4);
        shift_clock <= 1'b0;
        wait_n(4);
    endtask : shift_one

    task automatic send(input logic [15:0] w, input int n);
        logic [31:0] c;
        c = rnd();
        load_pulse();
        for (int k = 0; k < n; k++) begin
            shift_one(c[k]);
            chk("serial", 32'(first_bit_tap), 32'(exp_bit(w, c, k)));
            if (k < 8) chk("mid tap", 32'(mid_register_tap), 32'(w[k + 8]));
        end
    endtask : send

    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {word_load_strobe, shift_clock, cascade_serial_in, req, word} = '0;
        seed = 32'h11;
        err_count = 0;
        checks_done = 0;
        wait_n(5);
        presetn <= 1'b1;
        wait_n(5);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rdat, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk("mode", 32'(rdat[1:0]), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk("slverr", 32'(rerr), 32'h1);
        chk("rdata", rdat, 32'h0);
        q[0] = 16'(rnd());
        wr_word(q[0]);
        send(q[0], 32);
        for (int m = 1; m < 4; m += 2) begin
            apb(1'b1, 12'h000, 32'(m));
            q[0] = 16'(rnd());
            wr_word(q[0]);
            send(~q[0], 16);
        end
        apb(1'b1, 12'h000, 32'h2);
        wr_word(16'h0f0f);
        wr_word(16'hf0f0);
        word_load_strobe <= 1'b1;
        wait_n(5);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'h2);
        word_load_strobe <= 1'b0;
        wait_n(5);
        shift_one(1'b0);
        for (int n = 4; n < 6; n++) begin
            for (int i = 0; i < n; i++) begin
                q[i] = 16'(rnd());
                wr_word(q[i]);
            end
            for (int i = n - 4; i < n; i++) send(q[i], 16);
        end
        apb(1'b1, 12'h000, 32'h4);
        q[0] = 16'(rnd());
        q[1] = 16'(rnd());
        wr_word(q[0]);
        load_pulse();
        shift_one(1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk("shift", rdat, {16'h0, q[0]});
        apb(1'b1, 12'h000, 32'h24);
        wr_word(q[1]);
        load_pulse();
        shift_one(1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk("shift", rdat, {16'h0, q[0]});
        apb(1'b1, 12'h000, 32'h4);
        load_pulse();
        shift_one(1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk("shift", rdat, {16'h0, q[1]});
        q[2] = 16'(rnd());
        fork
            wr_word(q[2]);
            begin
                wait_n(7);
                word_load_strobe <= 1'b1;
                shift_one(1'b0);
                word_load_strobe <= 1'b0;
            end
        join
        apb(1'b0, 12'h008, 32'h0);
        chk("shift", rdat, {16'h0, q[1]});
        shift_one(1'b0);
        chk("serial", 32'(first_bit_tap), 32'(q[1][0]));
        apb(1'b1, 12'h000, 32'h0);
        wait_n(6);
        chk("serial", 32'(first_bit_tap), 32'(q[1][0]));
        shift_one(1'b0);
        chk("serial", 32'(first_bit_tap), 32'(q[1][1]));
        for (int lv = 0; lv < 2; lv++) begin
            apb(1'b1, 12'h000, 32'(8 + 16 * lv));
            shift_one(1'b0);
            chk("serial", 32'(first_bit_tap), 32'(lv));
            chk("mid tap", 32'(mid_register_tap), 32'(lv));
        end
        apb(1'b1, 12'h000, 32'h0);
        shift_one(1'b0);
        chk("serial", 32'(first_bit_tap), 32'(q[1][4]));
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
